// >>> design/erss_pkg.sv
package erss_pkg;

    // ======================================================================
    // register map, one aligned word per register
    // ======================================================================
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATE     = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h10;
    localparam logic [7:0] ADDR_START_DLY = 8'h14;
    localparam logic [7:0] ADDR_PRE_DLY   = 8'h18;
    localparam logic [7:0] ADDR_ECU_DLY   = 8'h1c;
    localparam logic [7:0] ADDR_CRK_ON    = 8'h20;
    localparam logic [7:0] ADDR_CRK_OFF   = 8'h24;
    localparam logic [7:0] ADDR_RETRY_DLY = 8'h28;
    localparam logic [7:0] ADDR_WARM_DLY  = 8'h2c;
    localparam logic [7:0] ADDR_STOP_DLY  = 8'h30;
    localparam logic [7:0] ADDR_COOL_DLY  = 8'h34;
    localparam logic [7:0] ADDR_LOCKOUT   = 8'h38;
    localparam logic [7:0] ADDR_SPEEDS    = 8'h3c;
    localparam logic [7:0] ADDR_CRK_STOP  = 8'h40;

    // ctrl register fields
    localparam int CTRL_ECU_BIT  = 0;
    localparam int CTRL_FILL_BIT = 1;

    // interrupt event bits
    localparam int IRQ_W         = 4;
    localparam int IRQ_SHUTDOWN  = 0;
    localparam int IRQ_RUNNING   = 1;
    localparam int IRQ_RETRY     = 2;
    localparam int IRQ_STOPPED   = 3;

    // reset values; delays are counts of 1 ms ticks
    localparam logic [15:0] RST_START_DLY = 16'h000a;
    localparam logic [15:0] RST_PRE_DLY   = 16'h000a;
    localparam logic [15:0] RST_ECU_DLY   = 16'h000a;
    localparam logic [15:0] RST_CRK_ON    = 16'h000a;
    localparam logic [15:0] RST_CRK_OFF   = 16'h000a;
    localparam logic [15:0] RST_RETRY_DLY = 16'h000a;
    localparam logic [15:0] RST_WARM_DLY  = 16'h000a;
    localparam logic [15:0] RST_STOP_DLY  = 16'h000a;
    localparam logic [15:0] RST_COOL_DLY  = 16'h000a;
    localparam logic [15:0] RST_LOCKOUT   = 16'h000a;
    localparam logic [15:0] RST_IDLE_RPM  = 16'h0320;
    localparam logic [15:0] RST_WARM_RPM  = 16'h04b0;
    localparam logic [15:0] RST_MIN_RPM   = 16'h05dc;
    localparam logic [15:0] RST_LOAD_RPM  = 16'h0708;
    localparam logic [15:0] RST_CRK_STOP  = 16'h012c;

    // timer tick: 1 ms at 50 MHz
    localparam int CLK_HZ        = 50000000;
    localparam int TICK_US       = 1000;
    localparam int TICK_CYC      = CLK_HZ / 1000000 * TICK_US;

    // key selector positions
    typedef enum logic [1:0] {
        ERSS_KEY_OFF  = 2'h0,
        ERSS_KEY_AUTO = 2'h1,
        ERSS_KEY_MAN  = 2'h2
    } erss_key_t;

    // gray codes along the start path
    typedef enum logic [3:0] {
        ERSS_NOT_READY   = 4'h0,
        ERSS_PANEL_READY = 4'h1,
        ERSS_START_DELAY = 4'h3,
        ERSS_PRESTART    = 4'h2,
        ERSS_ECU_WAIT    = 4'h6,
        ERSS_CRANK_ON    = 4'h7,
        ERSS_CRANK_OFF   = 4'h5,
        ERSS_RETRY_WAIT  = 4'h4,
        ERSS_WARMUP      = 4'hc,
        ERSS_LOADED_RUN  = 4'hd,
        ERSS_FILL        = 4'hf,
        ERSS_STOP_DELAY  = 4'he,
        ERSS_COOLDOWN    = 4'ha,
        ERSS_SHUTDOWN    = 4'hb
    } erss_state_t;

    typedef struct packed {
        logic low_oil;
        logic high_temp;
        logic overspeed;
    } erss_fault_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } erss_bus_t;

endpackage

// >>> design/erss_sequencer.sv
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module erss_sequencer #(
    parameter int TICK_CYC = erss_pkg::TICK_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire erss_pkg::erss_bus_t   bus_i,
    output logic [31:0]                rdata_o,
    input  wire logic [15:0]           speed_i,
    input  wire logic                  start_req_i,
    input  wire logic                  stop_req_i,
    input  wire erss_pkg::erss_fault_t fault_i,
    input  wire logic                  low_discharge_i,
    input  wire erss_pkg::erss_key_t   key_i,
    output logic                       crank_o,
    output logic                       prestart_o,
    output logic                       shutdown_o,
    output logic                       discharge_armed_o,
    output logic [15:0]                throttle_o,
    output logic [3:0]                 state_o,
    output logic                       irq_o
);

    // ======================================================================
    // registers
    // ======================================================================
    erss_pkg::erss_state_t state_r, state_nxt;
    logic [15:0] dly_r [0:9];
    logic [15:0] idle_rpm_r, warm_rpm_r, min_rpm_r, load_rpm_r, crk_stop_r;
    logic        ecu_type_r, fill_sel_r;
    logic [erss_pkg::IRQ_W-1:0] irq_stat_r, irq_en_r;
    logic [15:0] tmr_r, tmr_nxt;
    logic [15:0] lock_r, lock_nxt;
    logic [$clog2(TICK_CYC)-1:0] pre_r;
    logic        latch_r, saw_off_r;
    logic [31:0] rdata_r;

    // delay table indices
    localparam int D_START = 0;
    localparam int D_PRE   = 1;
    localparam int D_ECU   = 2;
    localparam int D_CON   = 3;
    localparam int D_COFF  = 4;
    localparam int D_RETRY = 5;
    localparam int D_WARM  = 6;
    localparam int D_STOP  = 7;
    localparam int D_COOL  = 8;
    localparam int D_LOCK  = 9;

    // ======================================================================
    // decode
    // ======================================================================
    wire tick    = (pre_r == '0);
    wire any_flt = fault_i.low_oil | fault_i.high_temp | fault_i.overspeed;
    wire key_off = (key_i == erss_pkg::ERSS_KEY_OFF);
    wire running = (state_r != erss_pkg::ERSS_NOT_READY) &&
                   (state_r != erss_pkg::ERSS_PANEL_READY) &&
                   (state_r != erss_pkg::ERSS_SHUTDOWN);
    wire started = (speed_i >= crk_stop_r);
    wire lock_done = (lock_r == '0);
    wire armed   = (state_r == erss_pkg::ERSS_LOADED_RUN);
    wire trip    = any_flt || (armed && low_discharge_i);
    wire stop_dn = (state_r == erss_pkg::ERSS_COOLDOWN) &&
                   (tmr_r == '0);
    wire wr_clr  = bus_i.wr && (bus_i.addr == erss_pkg::ADDR_IRQ_CLR);
    // clear needs a visit to off and a return to a live position
    wire unlatch = latch_r && saw_off_r && !key_off;
    wire [erss_pkg::IRQ_W-1:0] irq_evt = {
        stop_dn,
        state_nxt == erss_pkg::ERSS_RETRY_WAIT &&
            state_r != erss_pkg::ERSS_RETRY_WAIT,
        state_nxt == erss_pkg::ERSS_WARMUP &&
            state_r != erss_pkg::ERSS_WARMUP,
        state_nxt == erss_pkg::ERSS_SHUTDOWN &&
            state_r != erss_pkg::ERSS_SHUTDOWN};

    function automatic logic [15:0] dec(input logic [15:0] v,
                                        input logic t);
        dec = (t && v != '0) ? v - 16'h0001 : v;
    endfunction

    // ======================================================================
    // sequencer
    // ======================================================================
    always_comb
    begin
        state_nxt = state_r;
        tmr_nxt   = dec(tmr_r, tick);
        lock_nxt  = dec(lock_r, tick);
        unique case (state_r)
            erss_pkg::ERSS_NOT_READY:
                if (!key_off && !latch_r)
                    state_nxt = erss_pkg::ERSS_PANEL_READY;
            erss_pkg::ERSS_PANEL_READY:
                if (start_req_i)
                begin
                    state_nxt = erss_pkg::ERSS_START_DELAY;
                    tmr_nxt   = dly_r[D_START];
                end
            erss_pkg::ERSS_START_DELAY:
                if (!start_req_i)
                    state_nxt = erss_pkg::ERSS_PANEL_READY;
                else if (tmr_r == '0)
                begin
                    state_nxt = erss_pkg::ERSS_PRESTART;
                    tmr_nxt   = dly_r[D_PRE];
                end
            erss_pkg::ERSS_PRESTART:
                if (tmr_r == '0)
                begin
                    state_nxt = ecu_type_r ? erss_pkg::ERSS_ECU_WAIT
                                           : erss_pkg::ERSS_CRANK_ON;
                    tmr_nxt   = ecu_type_r ? dly_r[D_ECU]
                                           : dly_r[D_CON];
                end
            erss_pkg::ERSS_ECU_WAIT:
                if (tmr_r == '0)
                begin
                    state_nxt = erss_pkg::ERSS_CRANK_ON;
                    tmr_nxt   = dly_r[D_CON];
                end
            erss_pkg::ERSS_CRANK_ON:
                if (started)
                begin
                    state_nxt = erss_pkg::ERSS_WARMUP;
                    tmr_nxt   = dly_r[D_WARM];
                    lock_nxt  = dly_r[D_LOCK];
                end
                else if (tmr_r == '0)
                begin
                    state_nxt = erss_pkg::ERSS_CRANK_OFF;
                    tmr_nxt   = dly_r[D_COFF];
                end
            erss_pkg::ERSS_CRANK_OFF:
                if (tmr_r == '0)
                begin
                    state_nxt = erss_pkg::ERSS_CRANK_ON;
                    tmr_nxt   = dly_r[D_CON];
                end
            erss_pkg::ERSS_RETRY_WAIT:
                if (tmr_r == '0)
                begin
                    state_nxt = erss_pkg::ERSS_CRANK_ON;
                    tmr_nxt   = dly_r[D_CON];
                end
            erss_pkg::ERSS_WARMUP:
                if (!started && !lock_done)
                begin
                    state_nxt = erss_pkg::ERSS_RETRY_WAIT;
                    tmr_nxt   = dly_r[D_RETRY];
                end
                else if (tmr_r == '0)
                    state_nxt = fill_sel_r ? erss_pkg::ERSS_FILL
                                           : erss_pkg::ERSS_LOADED_RUN;
            erss_pkg::ERSS_LOADED_RUN, erss_pkg::ERSS_FILL:
                if (stop_req_i)
                begin
                    state_nxt = erss_pkg::ERSS_STOP_DELAY;
                    tmr_nxt   = dly_r[D_STOP];
                end
            erss_pkg::ERSS_STOP_DELAY:
                if (!stop_req_i)
                    state_nxt = fill_sel_r ? erss_pkg::ERSS_FILL
                                           : erss_pkg::ERSS_LOADED_RUN;
                else if (tmr_r == '0)
                begin
                    state_nxt = erss_pkg::ERSS_COOLDOWN;
                    tmr_nxt   = dly_r[D_COOL];
                end
            erss_pkg::ERSS_COOLDOWN:
                if (tmr_r == '0)
                    state_nxt = erss_pkg::ERSS_PANEL_READY;
            erss_pkg::ERSS_SHUTDOWN:
                if (unlatch)
                    state_nxt = erss_pkg::ERSS_PANEL_READY;
            default:
                state_nxt = erss_pkg::ERSS_NOT_READY;
        endcase
        if (running && trip)
            state_nxt = erss_pkg::ERSS_SHUTDOWN;
        else if (key_off && state_r != erss_pkg::ERSS_SHUTDOWN)
            state_nxt = erss_pkg::ERSS_NOT_READY;
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_r   <= erss_pkg::ERSS_NOT_READY;
            tmr_r     <= '0;
            lock_r    <= '0;
            pre_r     <= '0;
            latch_r   <= 1'b0;
            saw_off_r <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            tmr_r     <= tmr_nxt;
            lock_r    <= lock_nxt;
            pre_r     <= tick ? ($clog2(TICK_CYC))'(TICK_CYC - 1)
                              : pre_r - 1'b1;
            latch_r   <= (state_nxt == erss_pkg::ERSS_SHUTDOWN);
            saw_off_r <= latch_r && (saw_off_r || key_off);
        end
    end

    // ======================================================================
    // outputs, registered except the irq_o reduction
    // ======================================================================
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            crank_o           <= 1'b0;
            prestart_o        <= 1'b0;
            shutdown_o        <= 1'b0;
            discharge_armed_o <= 1'b0;
            throttle_o        <= '0;
        end
        else
        begin
            // crank rest and retry wait leave the starter off
            crank_o    <= (state_nxt == erss_pkg::ERSS_CRANK_ON);
            prestart_o <= (state_nxt == erss_pkg::ERSS_PRESTART);
            shutdown_o <= (state_nxt == erss_pkg::ERSS_SHUTDOWN);
            discharge_armed_o <= (state_nxt ==
                                  erss_pkg::ERSS_LOADED_RUN);
            unique case (state_nxt)
                erss_pkg::ERSS_WARMUP:     throttle_o <= warm_rpm_r;
                erss_pkg::ERSS_FILL:       throttle_o <= min_rpm_r;
                erss_pkg::ERSS_LOADED_RUN,
                erss_pkg::ERSS_STOP_DELAY: throttle_o <= load_rpm_r;
                erss_pkg::ERSS_COOLDOWN:   throttle_o <= idle_rpm_r;
                default:                   throttle_o <= '0;
            endcase
        end
    end

    assign state_o = state_r;
    assign irq_o   = |(irq_stat_r & irq_en_r);
    assign rdata_o = rdata_r;

    // ======================================================================
    // register bus
    // ======================================================================
    wire [15:0] wd16 = bus_i.wdata[15:0];
    wire        dly_hit = bus_i.addr >= erss_pkg::ADDR_START_DLY &&
                          bus_i.addr <= erss_pkg::ADDR_LOCKOUT &&
                          bus_i.addr[1:0] == 2'h0;
    wire [7:0]  dly_off = bus_i.addr - erss_pkg::ADDR_START_DLY;
    wire [3:0]  dly_idx = dly_off[5:2];

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            dly_r[D_START] <= erss_pkg::RST_START_DLY;
            dly_r[D_PRE]   <= erss_pkg::RST_PRE_DLY;
            dly_r[D_ECU]   <= erss_pkg::RST_ECU_DLY;
            dly_r[D_CON]   <= erss_pkg::RST_CRK_ON;
            dly_r[D_COFF]  <= erss_pkg::RST_CRK_OFF;
            dly_r[D_RETRY] <= erss_pkg::RST_RETRY_DLY;
            dly_r[D_WARM]  <= erss_pkg::RST_WARM_DLY;
            dly_r[D_STOP]  <= erss_pkg::RST_STOP_DLY;
            dly_r[D_COOL]  <= erss_pkg::RST_COOL_DLY;
            dly_r[D_LOCK]  <= erss_pkg::RST_LOCKOUT;
            idle_rpm_r <= erss_pkg::RST_IDLE_RPM;
            warm_rpm_r <= erss_pkg::RST_WARM_RPM;
            min_rpm_r  <= erss_pkg::RST_MIN_RPM;
            load_rpm_r <= erss_pkg::RST_LOAD_RPM;
            crk_stop_r <= erss_pkg::RST_CRK_STOP;
            ecu_type_r <= 1'b0;
            fill_sel_r <= 1'b0;
            irq_en_r   <= '0;
        end
        else if (bus_i.wr)
        begin
            if (dly_hit)
                dly_r[dly_idx] <= wd16;
            unique case (bus_i.addr)
                erss_pkg::ADDR_CTRL:
                begin
                    ecu_type_r <= bus_i.wdata[erss_pkg::CTRL_ECU_BIT];
                    fill_sel_r <= bus_i.wdata[erss_pkg::CTRL_FILL_BIT];
                end
                erss_pkg::ADDR_IRQ_EN:
                    irq_en_r <= bus_i.wdata[erss_pkg::IRQ_W-1:0];
                erss_pkg::ADDR_SPEEDS:
                begin
                    idle_rpm_r <= wd16;
                    warm_rpm_r <= bus_i.wdata[31:16];
                end
                erss_pkg::ADDR_CRK_STOP:
                begin
                    crk_stop_r <= wd16;
                    min_rpm_r  <= bus_i.wdata[31:16];
                end
                default:
                    load_rpm_r <= load_rpm_r;
            endcase
        end
    end

    // event set wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (irq_stat_r &
                           ~(wr_clr ? bus_i.wdata[erss_pkg::IRQ_W-1:0]
                                    : '0)) | irq_evt;
    end

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (dly_hit)
            rd_mux = {16'h0000, dly_r[dly_idx]};
        else
            unique case (bus_i.addr)
                erss_pkg::ADDR_CTRL:     rd_mux = {30'h0, fill_sel_r,
                                                   ecu_type_r};
                erss_pkg::ADDR_STATE:    rd_mux = {26'h0, discharge_armed_o,
                                                   latch_r, state_r};
                erss_pkg::ADDR_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
                erss_pkg::ADDR_IRQ_EN:   rd_mux = {28'h0, irq_en_r};
                erss_pkg::ADDR_SPEEDS:   rd_mux = {warm_rpm_r, idle_rpm_r};
                erss_pkg::ADDR_CRK_STOP: rd_mux = {min_rpm_r, crk_stop_r};
                default:                 rd_mux = 32'h0000_0000;
            endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            rdata_r <= '0;
        else
            rdata_r <= bus_i.rd ? rd_mux : 32'h0000_0000;
    end

endmodule

// >>> testbench/erss_sequencer_props.sv
`timescale 1ns/1ns
// ==============================
// state and output relations
// ==============================
module erss_sequencer_props (
    input wire logic                  clk_i,
    input wire logic                  resetn_i,
    input wire logic                  start_req_i,
    input wire logic                  stop_req_i,
    input wire erss_pkg::erss_fault_t fault_i,
    input wire erss_pkg::erss_key_t   key_i,
    input wire logic                  crank_o,
    input wire logic                  prestart_o,
    input wire logic                  shutdown_o,
    input wire logic                  discharge_armed_o,
    input wire logic [15:0]           throttle_o,
    input wire logic [3:0]            state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic key_on;
    logic live;
    assign key_on = key_i != erss_pkg::ERSS_KEY_OFF;
    // faults only count where the engine may be turning
    assign live = key_on && !(state_o inside {4'h0, 4'h1, 4'hb});

    reset_clear_a: assert property (
        $rose(resetn_i) |-> state_o == 4'h0 && !crank_o && !shutdown_o)
        else $error("outputs active after reset");
    crank_out_a: assert property (
        crank_o == (state_o == erss_pkg::ERSS_CRANK_ON))
        else $error("crank output wrong for state");
    prestart_out_a: assert property (
        prestart_o == (state_o == erss_pkg::ERSS_PRESTART))
        else $error("prestart output wrong for state");
    warm_throttle_a: assert property (
        state_o == erss_pkg::ERSS_WARMUP |->
        throttle_o == erss_pkg::RST_WARM_RPM)
        else $error("warm-up throttle wrong");
    loaded_armed_a: assert property (
        discharge_armed_o == (state_o == erss_pkg::ERSS_LOADED_RUN))
        else $error("discharge trip arming wrong");
    fill_throttle_a: assert property (
        state_o == erss_pkg::ERSS_FILL |->
        throttle_o == erss_pkg::RST_MIN_RPM)
        else $error("fill throttle wrong");
    cool_idle_a: assert property (
        state_o == erss_pkg::ERSS_COOLDOWN |->
        throttle_o == erss_pkg::RST_IDLE_RPM)
        else $error("cooldown throttle wrong");
    fault_trip_a: assert property (
        fault_i != 3'h0 && live |=>
        state_o == erss_pkg::ERSS_SHUTDOWN && shutdown_o)
        else $error("fault did not shut down");
    latch_hold_a: assert property (
        state_o == erss_pkg::ERSS_SHUTDOWN && key_on && $past(key_on) |=>
        state_o == erss_pkg::ERSS_SHUTDOWN)
        else $error("shutdown latch left");
    // the latch holds through key off and lets go on the return
    latch_clear_a: assert property (
        state_o == erss_pkg::ERSS_SHUTDOWN && !key_on |=>
        state_o == erss_pkg::ERSS_SHUTDOWN)
        else $error("key off alone left shutdown");
    latch_release_a: assert property (
        state_o == erss_pkg::ERSS_SHUTDOWN && key_on && !$past(key_on) &&
        $past(state_o) == erss_pkg::ERSS_SHUTDOWN |=> state_o == 4'h1)
        else $error("key return did not clear latch");
    stop_abandon_a: assert property (
        state_o == erss_pkg::ERSS_STOP_DELAY && !stop_req_i |=>
        state_o != erss_pkg::ERSS_COOLDOWN)
        else $error("dropped stop reached cooldown");
    start_qualify_a: assert property (
        state_o == erss_pkg::ERSS_START_DELAY && !start_req_i |=>
        state_o != erss_pkg::ERSS_PRESTART)
        else $error("dropped start reached prestart");
endmodule

bind erss_sequencer erss_sequencer_props u_erss_sequencer_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .start_req_i(start_req_i),
    .stop_req_i(stop_req_i), .fault_i(fault_i), .key_i(key_i),
    .crank_o(crank_o), .prestart_o(prestart_o), .shutdown_o(shutdown_o),
    .discharge_armed_o(discharge_armed_o), .throttle_o(throttle_o),
    .state_o(state_o));

// >>> testbench/erss_engine_model.sv
`timescale 1ns/1ns
// ==============================
// engine: fires after enough crank time
// ==============================
module erss_engine_model #(
    parameter int FIRE_CYC = 60
) (
    input  wire logic   clk_i,
    input  wire logic   crank_i,
    input  wire logic   shutdown_i,
    input  wire logic   stall_i,
    output logic [15:0] speed_o
);
    int   crank_cnt = 0;
    logic run_r     = 1'b0;
    // cranking speed sits under crank-stop, so only firing ends a crank before its on-time runs out
    assign speed_o = run_r ? 16'h0600 : (crank_i ? 16'h00c8 : 16'h0000);
    always @(posedge clk_i)
    begin
        if (shutdown_i)
            crank_cnt <= 0;
        else if (crank_i)
            crank_cnt <= crank_cnt + 1;
        if (shutdown_i || stall_i)
            run_r <= 1'b0;
        else if (crank_i && crank_cnt >= FIRE_CYC)
            run_r <= 1'b1;
    end
endmodule

// >>> testbench/erss_sequencer_bench.sv
`timescale 1ns/1ns
module erss_sequencer_bench;
    // ==============================
    // signals
    // ==============================
    localparam int T10 = 48;
    logic                  clk_i = 1'b0;
    logic                  resetn_i = 1'b0;
    erss_pkg::erss_bus_t   bus_i = '0;
    logic [31:0]           rdata_o;
    logic [15:0]           speed_i;
    logic                  start_req_i = 1'b0;
    logic                  stop_req_i = 1'b0;
    erss_pkg::erss_fault_t fault_i = '0;
    erss_pkg::erss_key_t   key_i = erss_pkg::ERSS_KEY_OFF;
    logic                  crank_o, prestart_o, shutdown_o, armed_o, irq_o;
    logic [15:0]           throttle_o;
    logic [3:0]            state_o;
    logic                  stall = 1'b0;
    logic                  low_dis = 1'b0;
    int                    fail_count = 0;
    int                    total_checks = 0;

    always #10 clk_i = ~clk_i;

    erss_sequencer #(.TICK_CYC(4)) u_erss_sequencer (
        .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .speed_i(speed_i), .start_req_i(start_req_i),
        .stop_req_i(stop_req_i), .fault_i(fault_i), .low_discharge_i(low_dis),
        .key_i(key_i), .crank_o(crank_o), .prestart_o(prestart_o),
        .shutdown_o(shutdown_o), .discharge_armed_o(armed_o),
        .throttle_o(throttle_o), .state_o(state_o), .irq_o(irq_o));
    erss_engine_model u_erss_engine_model (
        .clk_i(clk_i), .crank_i(crank_o), .shutdown_i(shutdown_o),
        .stall_i(stall), .speed_o(speed_i));

    // ==============================
    // tasks
    // ==============================
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask
    // timeout is a mismatch and ends the run
    task automatic wait_state(input logic [3:0] s);
        int n;
        n = 0;
        while (state_o !== s && n < 3000)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n == 3000)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, state_o, s);
            summarize();
        end
    endtask

    // ==============================
    // sequence
    // ==============================
    initial
    begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1;
        check({state_o, crank_o, prestart_o, shutdown_o}, 7'h0);
        rd(erss_pkg::ADDR_STATE, 32'h0);
        rd(8'h7c, 32'h0);
        wr(erss_pkg::ADDR_WARM_DLY, 32'h1e);
        wr(erss_pkg::ADDR_IRQ_EN, 32'hf);
        wr(erss_pkg::ADDR_CTRL, 32'h1);
        key_i <= erss_pkg::ERSS_KEY_AUTO;
        wait_state(erss_pkg::ERSS_PANEL_READY);
        start_req_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        start_req_i <= 1'b0;
        repeat (T10) @(posedge clk_i);
        #1 check(state_o, erss_pkg::ERSS_PANEL_READY);
        start_req_i <= 1'b1;
        wait_state(erss_pkg::ERSS_PRESTART);
        check(prestart_o, 1'b1);
        wait_state(erss_pkg::ERSS_ECU_WAIT);
        wait_state(erss_pkg::ERSS_CRANK_ON);
        check(crank_o, 1'b1);
        wait_state(erss_pkg::ERSS_CRANK_OFF);
        check(crank_o, 1'b0);
        wait_state(erss_pkg::ERSS_WARMUP);
        check(throttle_o, erss_pkg::RST_WARM_RPM);
        start_req_i <= 1'b0;
        stall <= 1'b1;
        wait_state(erss_pkg::ERSS_RETRY_WAIT);
        stall <= 1'b0;
        wait_state(erss_pkg::ERSS_WARMUP);
        rd(erss_pkg::ADDR_IRQ_STAT, 32'h6);
        wr(erss_pkg::ADDR_IRQ_EN, 32'h0);
        check(irq_o, 1'b0);
        wr(erss_pkg::ADDR_IRQ_EN, 32'hf);
        check(irq_o, 1'b1);
        wr(erss_pkg::ADDR_IRQ_CLR, 32'hf);
        check(irq_o, 1'b0);
        wait_state(erss_pkg::ERSS_LOADED_RUN);
        check(armed_o, 1'b1);
        stop_req_i <= 1'b1;
        wait_state(erss_pkg::ERSS_STOP_DELAY);
        stop_req_i <= 1'b0;
        repeat (T10) @(posedge clk_i);
        #1 check(state_o, erss_pkg::ERSS_LOADED_RUN);
        stop_req_i <= 1'b1;
        wait_state(erss_pkg::ERSS_COOLDOWN);
        check(throttle_o, erss_pkg::RST_IDLE_RPM);
        stop_req_i <= 1'b0;
        wait_state(erss_pkg::ERSS_PANEL_READY);
        stall <= 1'b1;
        wr(erss_pkg::ADDR_CTRL, 32'h2);
        stall <= 1'b0;
        start_req_i <= 1'b1;
        wait_state(erss_pkg::ERSS_WARMUP);
        start_req_i <= 1'b0;
        wait_state(erss_pkg::ERSS_FILL);
        check(throttle_o, erss_pkg::RST_MIN_RPM);
        low_dis <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1 check(state_o, erss_pkg::ERSS_FILL);
        low_dis <= 1'b0;
        fault_i <= erss_pkg::erss_fault_t'(3'h1);
        wait_state(erss_pkg::ERSS_SHUTDOWN);
        check(shutdown_o, 1'b1);
        fault_i <= '0;
        // each fault kind, tripped while the start is qualifying
        for (int i = 0; i < 3; i++)
        begin
            start_req_i <= 1'b1;
            key_i <= erss_pkg::ERSS_KEY_MAN;
            repeat (T10) @(posedge clk_i);
            #1 check(state_o, erss_pkg::ERSS_SHUTDOWN);
            key_i <= erss_pkg::ERSS_KEY_OFF;
            repeat (4) @(posedge clk_i);
            #1 check(state_o, erss_pkg::ERSS_SHUTDOWN);
            key_i <= erss_pkg::ERSS_KEY_AUTO;
            wait_state(erss_pkg::ERSS_START_DELAY);
            fault_i <= erss_pkg::erss_fault_t'(3'h1 << i);
            wait_state(erss_pkg::ERSS_SHUTDOWN);
            fault_i <= '0;
        end
        rd(erss_pkg::ADDR_IRQ_STAT, 32'hb);
        check(irq_o, 1'b1);
        // discharge trip only counts once the loaded run is reached
        wr(erss_pkg::ADDR_CTRL, 32'h0);
        key_i <= erss_pkg::ERSS_KEY_OFF;
        @(posedge clk_i);
        key_i <= erss_pkg::ERSS_KEY_AUTO;
        wait_state(erss_pkg::ERSS_LOADED_RUN);
        low_dis <= 1'b1;
        wait_state(erss_pkg::ERSS_SHUTDOWN);
        check(shutdown_o, 1'b1);
        summarize();
    end
endmodule
